/* File: verilog/imbc_defs.vh */
// Constants for the I2C special-mode bus control block
// Notes on behaviour
// - Master syncs generated clock to line level
// - Hold clock low from ninth-bit fall
// - Release data output on arbitration lost
// - Slave reinitialises channel on start detect
// - Forced clock low overrides everything
// - Data output disable releases data line
// - Data output delayed by selected amount
// - Delay is none or 2 to 8 bit-rate ticks
// - Start request generates start condition
// - Restart request generates repeated start
// - Stop request generates stop condition
// - Conditions output only when generator selected
// - Ack output drives ACK or NACK
// - Stop clock output after stop detected
// - Slave ninth-clock hold keeps clock low
// - Interrupt source and phase change timing
`ifndef IMBC_DEFS_VH
`define IMBC_DEFS_VH
`define IMBC_ADDR_CTL2     2'h0
`define IMBC_ADDR_CTL3     2'h1
`define IMBC_ADDR_CTL4     2'h2
`define IMBC_ADDR_COMMON   2'h3
`define IMBC_CTL2_RESET    8'h00
`define IMBC_CTL3_RESET    8'h00
`define IMBC_CTL4_RESET    8'h00
`define IMBC_COMMON_RESET  8'h00
`define IMBC_C2_ISRC       0
`define IMBC_C2_CSYNC      1
`define IMBC_C2_HOLD9      2
`define IMBC_C2_ALREL      3
`define IMBC_C2_STARST     4
`define IMBC_C2_FORCELO    5
`define IMBC_C2_SDADIS     6
`define IMBC_C3_CLOCK_PHASE_DELAY       1
`define IMBC_C3_DLY_LSB    5
`define IMBC_C4_START      0
`define IMBC_C4_RESTART    1
`define IMBC_C4_STOP       2
`define IMBC_C4_CONDSEL    3
`define IMBC_C4_ACKSEL     4
`define IMBC_C4_ACKEN      5
`define IMBC_C4_CLKSTOP    6
`define IMBC_C4_SHOLD9     7
`define IMBC_C4_WMASK      8'h07
`define IMBC_DLY_MIN       4'h2
`define IMBC_BRG_RESET     8'h03
`endif

/* File: verilog/imbc_sync.v */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module imbc_sync (
   input  wire clk,
   input  wire rst,
   input  wire din,
   output reg  dout
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   // Idle-high reset suits open-drain lines
   always @(posedge clk) begin
      if (rst) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         dout   <= 1'b1;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            dout <= s3_reg;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verilog/imbc_top.v */
// I2C special-mode bus control: registers, condition generator, clock and data drive
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "imbc_defs.vh"
module imbc_top #(
   parameter BRG_W = 8
) (
   input  wire             clk,
   input  wire             rst,
   input  wire [1:0]       reg_addr,
   input  wire [7:0]       reg_wdata,
   input  wire             reg_wr,
   input  wire             reg_rd,
   output reg  [7:0]       reg_rdata,
   input  wire             master_mode,
   input  wire [BRG_W-1:0] bit_rate_div,
   input  wire             tx_data_bit,
   input  wire             arb_lost,
   input  wire             scl_in,
   output wire             scl_out,
   output wire             scl_oe,
   input  wire             sda_in,
   output wire             sda_out,
   output wire             sda_oe,
   output reg              start_detect,
   output reg              stop_detect,
   output reg              channel_reinit,
   output reg              ninth_fall,
   output reg              ack_event,
   output reg              nack_event,
   output reg              xfer_event,
   output reg              rx_load,
   output reg              bus_busy,
   output reg  [7:0]       rx_data
);
   localparam ST_IDLE = 3'd0;
   localparam ST_S1   = 3'd1;
   localparam ST_S2   = 3'd2;
   localparam ST_P1   = 3'd3;
   localparam ST_P2   = 3'd4;
   localparam ST_R1   = 3'd5;

   reg [7:0] ctl2_reg;
   reg [7:0] ctl3_reg;
   reg [7:0] ctl4_reg;
   reg [7:0] common_reg;
   reg [2:0] st_reg;
   reg [BRG_W-1:0] brg_reg;
   reg       tick_reg;
   reg       scl_q_reg;
   reg       sda_q_reg;
   reg [3:0] bit_cnt_reg;
   reg       hold_reg;
   reg       clk_stopped_reg;
   reg       arb_rel_reg;
   reg       gen_scl_reg;
   reg       gen_sda_reg;
   reg       cond_scl_reg;
   reg       cond_sda_reg;
   reg [8:0] dly_pipe_reg;
   reg [8:0] shift_reg;
   wire      scl_s;
   wire      sda_s;

   // Both lines share one synchroniser depth so their edges stay aligned
   imbc_sync u_scl (
      .clk  (clk),
      .rst  (rst),
      .din  (scl_in),
      .dout (scl_s)
   );
   imbc_sync u_sda (
      .clk  (clk),
      .rst  (rst),
      .din  (sda_in),
      .dout (sda_s)
   );

   wire scl_rise = scl_s & ~scl_q_reg;
   wire scl_fall = ~scl_s & scl_q_reg;
   wire sda_rise = sda_s & ~sda_q_reg;
   wire sda_fall = ~sda_s & sda_q_reg;
   wire start_ev = sda_fall & scl_s;
   wire stop_ev  = sda_rise & scl_s;
   wire [2:0] dly_sel = ctl3_reg[`IMBC_C3_DLY_LSB+2:`IMBC_C3_DLY_LSB];
   wire isrc = ctl2_reg[`IMBC_C2_ISRC];
   wire clock_phase_delay = ctl3_reg[`IMBC_C3_CLOCK_PHASE_DELAY];

   // Register bus; request bits self-clear when the condition completes
   always @(posedge clk) begin
      if (rst) begin
         ctl2_reg   <= `IMBC_CTL2_RESET;
         ctl3_reg   <= `IMBC_CTL3_RESET;
         ctl4_reg   <= `IMBC_CTL4_RESET;
         common_reg <= `IMBC_COMMON_RESET;
         reg_rdata  <= 8'h00;
      end else begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `IMBC_ADDR_CTL2:   reg_rdata <= ctl2_reg;
               `IMBC_ADDR_CTL3:   reg_rdata <= ctl3_reg;
               `IMBC_ADDR_CTL4:   reg_rdata <= ctl4_reg;
               `IMBC_ADDR_COMMON: reg_rdata <= common_reg;
               default:           reg_rdata <= 8'h00;
            endcase
         end
         if (reg_wr && reg_addr == `IMBC_ADDR_CTL2) begin
            ctl2_reg <= {1'b0, reg_wdata[6:0]};
         end
         if (reg_wr && reg_addr == `IMBC_ADDR_CTL3) begin
            ctl3_reg <= reg_wdata;
         end
         if (reg_wr && reg_addr == `IMBC_ADDR_COMMON) begin
            common_reg <= {1'b0, reg_wdata[6:0]};
         end
         if (reg_wr && reg_addr == `IMBC_ADDR_CTL4) begin
            // Request bits are set-only from software
            ctl4_reg <= reg_wdata | (ctl4_reg & `IMBC_C4_WMASK);
         end
         if (st_reg == ST_S2 && tick_reg) begin
            ctl4_reg[`IMBC_C4_START]   <= 1'b0;
            ctl4_reg[`IMBC_C4_RESTART] <= 1'b0;
         end
         if (st_reg == ST_P2 && tick_reg) begin
            ctl4_reg[`IMBC_C4_STOP] <= 1'b0;
         end
      end
   end

   // Bit-rate count source tick; holds while line clock is stretched
   always @(posedge clk) begin
      if (rst) begin
         brg_reg  <= {BRG_W{1'b0}};
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= 1'b0;
         if (ctl2_reg[`IMBC_C2_CSYNC] && master_mode && gen_scl_reg && !scl_s) begin
            brg_reg <= brg_reg;
         end else if (brg_reg >= bit_rate_div) begin
            brg_reg  <= {BRG_W{1'b0}};
            tick_reg <= 1'b1;
         end else begin
            brg_reg <= brg_reg + 1'b1;
         end
      end
   end

   // Condition generator
   always @(posedge clk) begin
      if (rst) begin
         st_reg       <= ST_IDLE;
         cond_scl_reg <= 1'b1;
         cond_sda_reg <= 1'b1;
      end else if (tick_reg) begin
         case (st_reg)
            ST_IDLE: begin
               if (ctl4_reg[`IMBC_C4_START] && master_mode) begin
                  st_reg       <= ST_S1;
                  cond_scl_reg <= 1'b1;
                  cond_sda_reg <= 1'b1;
               end else if (ctl4_reg[`IMBC_C4_RESTART] && master_mode) begin
                  st_reg       <= ST_R1;
                  cond_scl_reg <= 1'b0;
                  cond_sda_reg <= 1'b1;
               end else if (ctl4_reg[`IMBC_C4_STOP] && master_mode) begin
                  st_reg       <= ST_P1;
                  cond_scl_reg <= 1'b0;
                  cond_sda_reg <= 1'b0;
               end
            end
            ST_R1: begin
               cond_scl_reg <= 1'b1;
               st_reg       <= ST_S1;
            end
            ST_S1: begin
               cond_sda_reg <= 1'b0;
               st_reg       <= ST_S2;
            end
            ST_S2: begin
               cond_scl_reg <= 1'b0;
               st_reg       <= ST_IDLE;
            end
            ST_P1: begin
               cond_scl_reg <= 1'b1;
               st_reg       <= ST_P2;
            end
            ST_P2: begin
               cond_sda_reg <= 1'b1;
               st_reg       <= ST_IDLE;
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // Bus watch, bit count, holds and events
   always @(posedge clk) begin
      if (rst) begin
         scl_q_reg       <= 1'b1;
         sda_q_reg       <= 1'b1;
         bit_cnt_reg     <= 4'h0;
         hold_reg        <= 1'b0;
         clk_stopped_reg <= 1'b0;
         arb_rel_reg     <= 1'b0;
         start_detect    <= 1'b0;
         stop_detect     <= 1'b0;
         channel_reinit  <= 1'b0;
         ninth_fall      <= 1'b0;
         ack_event       <= 1'b0;
         nack_event      <= 1'b0;
         xfer_event      <= 1'b0;
         rx_load         <= 1'b0;
         bus_busy        <= 1'b0;
         shift_reg       <= 9'h000;
         rx_data         <= 8'h00;
      end else begin
         scl_q_reg      <= scl_s;
         sda_q_reg      <= sda_s;
         start_detect   <= start_ev;
         stop_detect    <= stop_ev;
         ninth_fall     <= scl_fall && bit_cnt_reg == 4'd9;
         channel_reinit <= 1'b0;
         ack_event      <= 1'b0;
         nack_event     <= 1'b0;
         xfer_event     <= 1'b0;
         rx_load        <= 1'b0;
         if (start_ev) begin
            bus_busy <= 1'b1;
         end else if (stop_ev) begin
            bus_busy <= 1'b0;
         end
         if (scl_rise) begin
            shift_reg <= {shift_reg[7:0], sda_s};
         end
         // source and phase select
         // The ninth rising edge is seen with the count at nine; the shift
         // register then still holds the eight data bits in its low byte
         if (!isrc && scl_rise && bit_cnt_reg == 4'd9) begin
            ack_event  <= ~sda_s;
            nack_event <= sda_s;
            rx_load    <= 1'b1;
            rx_data    <= shift_reg[7:0];
         end else if (isrc && !clock_phase_delay && scl_rise && bit_cnt_reg == 4'd9) begin
            xfer_event <= 1'b1;
         end else if (isrc && scl_fall && bit_cnt_reg == 4'd9) begin
            ack_event  <= ~shift_reg[0];
            xfer_event <= clock_phase_delay;
            rx_load    <= 1'b1;
            rx_data    <= shift_reg[8:1];
         end
         // Delayed phase loads early and again at the ninth fall
         if (isrc && clock_phase_delay && scl_rise && bit_cnt_reg == 4'd9) begin
            rx_load <= 1'b1;
            rx_data <= shift_reg[7:0];
         end
         // Count stands at nine from the eighth fall to the ninth fall,
         // which is the window in which the acknowledge bit is driven
         if (start_ev) begin
            bit_cnt_reg <= 4'h0;
         end else if (scl_fall && bit_cnt_reg == 4'd9) begin
            bit_cnt_reg <= 4'h1;
         end else if (scl_rise && bit_cnt_reg == 4'd0) begin
            bit_cnt_reg <= 4'h1;
         end else if (scl_fall && bit_cnt_reg != 4'd0) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
         if (scl_fall && bit_cnt_reg == 4'd9 &&
             (ctl2_reg[`IMBC_C2_HOLD9] ||
              (ctl4_reg[`IMBC_C4_SHOLD9] && !master_mode))) begin
            hold_reg <= 1'b1;
         end else if (!ctl2_reg[`IMBC_C2_HOLD9] &&
                      !(ctl4_reg[`IMBC_C4_SHOLD9] && !master_mode)) begin
            hold_reg <= 1'b0;
         end
         if (stop_ev && master_mode && ctl4_reg[`IMBC_C4_CLKSTOP]) begin
            clk_stopped_reg <= 1'b1;
         end else if (start_ev || !ctl4_reg[`IMBC_C4_CLKSTOP]) begin
            clk_stopped_reg <= 1'b0;
         end
         if (arb_lost && master_mode && ctl2_reg[`IMBC_C2_ALREL]) begin
            arb_rel_reg <= 1'b1;
         end else if (start_ev || !ctl2_reg[`IMBC_C2_ALREL]) begin
            arb_rel_reg <= 1'b0;
         end
         if (start_ev && !master_mode && ctl2_reg[`IMBC_C2_STARST]) begin
            channel_reinit <= 1'b1;
            bit_cnt_reg    <= 4'h0;
            shift_reg      <= 9'h000;
         end
      end
   end

   // Data source selection and delay line
   always @(posedge clk) begin
      if (rst) begin
         gen_scl_reg  <= 1'b1;
         gen_sda_reg  <= 1'b1;
         dly_pipe_reg <= 9'h1ff;
      end else begin
         if (ctl4_reg[`IMBC_C4_CONDSEL] && master_mode) begin
            gen_scl_reg <= cond_scl_reg;
            gen_sda_reg <= cond_sda_reg;
         // ack drive
         // Only during the ninth bit; driving it all frame would mask the
         // master's start and data bits on the shared line
         end else if (ctl4_reg[`IMBC_C4_ACKEN] && bit_cnt_reg == 4'd9) begin
            gen_scl_reg <= master_mode ? scl_s : 1'b1;
            gen_sda_reg <= ctl4_reg[`IMBC_C4_ACKSEL];
         end else begin
            gen_scl_reg <= master_mode ? scl_s : 1'b1;
            gen_sda_reg <= tx_data_bit;
         end
         if (tick_reg) begin
            dly_pipe_reg <= {dly_pipe_reg[7:0], gen_sda_reg};
         end
      end
   end

   // none, or 2 to 8 ticks
   // Pipe tap n gives n+1 ticks of delay; the shortest setting is two
   // ticks because the first stage already adds one
   wire sda_dly = (dly_sel == 3'd0) ? gen_sda_reg :
                  dly_pipe_reg[{1'b0, dly_sel} + `IMBC_DLY_MIN - 4'h2];
   wire scl_low = ctl2_reg[`IMBC_C2_FORCELO] | hold_reg |
                  (~clk_stopped_reg & ~gen_scl_reg);
   // Open drain: the pins only ever pull low, the enables carry the level
   // forced low wins
   assign scl_out = 1'b0;
   assign scl_oe  = scl_low;
   assign sda_out = 1'b0;
   assign sda_oe  = ~ctl2_reg[`IMBC_C2_SDADIS] & ~arb_rel_reg & ~sda_dly;
endmodule
`default_nettype wire

/* File: testbench/imbc_top_asserts.sv */
// Port-level checks for the I2C special-mode bus control block
`timescale 1ns/1ps
`default_nettype none
module imbc_top_asserts #(
   parameter BRG_W = 8
) (
   input wire logic             clk,
   input wire logic             rst,
   input wire logic [1:0]       reg_addr,
   input wire logic [7:0]       reg_wdata,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [7:0]       reg_rdata,
   input wire logic             master_mode,
   input wire logic [BRG_W-1:0] bit_rate_div,
   input wire logic             arb_lost,
   input wire logic             scl_out,
   input wire logic             scl_oe,
   input wire logic             sda_out,
   input wire logic             sda_oe,
   input wire logic             start_detect,
   input wire logic             channel_reinit,
   input wire logic             ninth_fall
);
   logic [7:0] c2, c3, c4, cm;
   wire  [7:0] shadow = (reg_addr == 2'h0) ? c2 : (reg_addr == 2'h1) ? c3 :
                        (reg_addr == 2'h2) ? c4 : cm;
   // Request bits self-clear, so only the stored ctl_four bits are compared
   wire  [7:0] rmask  = (reg_addr == 2'h2) ? 8'hF8 : 8'hFF;
   always_ff @(posedge clk) begin
      if (rst) begin
         c2 <= 8'h00;
         c3 <= 8'h00;
         c4 <= 8'h00;
         cm <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            2'h0: c2 <= reg_wdata & 8'h7F;
            2'h1: c3 <= reg_wdata;
            2'h2: c4 <= reg_wdata & 8'hF8;
            default: cm <= reg_wdata & 8'h7F;
         endcase
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Bound on the divider keeps the wait for the start inside the window
   sequence s_start_req;
      reg_wr && reg_addr == 2'h2 && reg_wdata[0] && reg_wdata[3] && master_mode
         && c2[6:5] == 2'b00 && bit_rate_div < 16;
   endsequence
   sequence s_start_out;
      ##[1:1000] ($rose(sda_oe) && !scl_oe);
   endsequence
   a_pins_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("open-drain outputs not low");
   a_read_back: assert property ($past(reg_rd) |-> (reg_rdata & $past(rmask)) == $past(shadow))
      else $error("read data differs from written value");
   a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read cycle");
   a_forced_low: assert property (c2[5] |-> scl_oe)
      else $error("clock not forced low");
   a_data_release: assert property (c2[6] |-> !sda_oe)
      else $error("data driven while disabled");
   a_arb_release: assert property (arb_lost && master_mode && c2[3] |-> ##[0:3] !sda_oe)
      else $error("data driven after arbitration lost");
   a_start_gen: assert property (s_start_req |-> s_start_out)
      else $error("no start condition generated");
   a_start_reinit: assert property (start_detect && !master_mode && c2[4] |-> ##[0:2] channel_reinit)
      else $error("no reinit on start");
   a_ninth_hold: assert property (ninth_fall && (c2[2] || (c4[7] && !master_mode)) |-> ##[0:4] scl_oe)
      else $error("clock not held after ninth bit");
   a_hold_release: assert property (!master_mode && !c2[5] && !c2[2] && !c4[7]
      && ($fell(c2[2]) || $fell(c4[7])) |-> ##[0:2] !scl_oe)
      else $error("clock not released after hold cleared");
endmodule
bind imbc_top imbc_top_asserts #(.BRG_W(BRG_W)) i_imbc_top_asserts (.clk(clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .master_mode(master_mode), .bit_rate_div(bit_rate_div),
   .arb_lost(arb_lost), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
   .sda_oe(sda_oe), .start_detect(start_detect), .channel_reinit(channel_reinit),
   .ninth_fall(ninth_fall));
`default_nettype wire

/* File: testbench/imbc_peer.sv */
// Behavioural bus master peer: start, eight data bits, ack bit, stop
`timescale 1ns/1ps
`default_nettype none
module imbc_peer (
   input  wire logic       go,
   input  wire logic [7:0] tx_byte,
   input  wire logic       scl,
   input  wire logic       sda,
   output var  logic       scl_low,
   output var  logic       sda_low,
   output var  logic       busy,
   output var  logic       ack_bit
);
   integer n;
   logic   s;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      busy = 1'b0;
      ack_bit = 1'b1;
   end
   task bit_cyc(input logic d, output logic q);
      sda_low = !d;
      #40 scl_low = 1'b0;
      // The slave may stretch the clock, so wait for the line itself
      wait (scl);
      #80 q = sda;
      scl_low = 1'b1;
      #40;
   endtask
   always begin
      @(posedge go);
      busy = 1'b1;
      sda_low = 1'b1;
      #80 scl_low = 1'b1;
      #40;
      for (n = 7; n >= 0; n--) bit_cyc(tx_byte[n], s);
      bit_cyc(1'b1, ack_bit);
      sda_low = 1'b1;
      #40 scl_low = 1'b0;
      wait (scl);
      #80 sda_low = 1'b0;
      #80 busy = 1'b0;
   end
endmodule
`default_nettype wire

/* File: testbench/test_imbc_top.sv */
// Self-checking bench for the I2C special-mode bus control block
`timescale 1ns/1ps
`default_nettype none
module test_imbc_top;
   logic       clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
   logic       master_mode = 1'b0, tx_data_bit = 1'b1, arb_lost = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00, bit_rate_div = 8'h03, byte_v = 8'h00, v;
   wire  [7:0] reg_rdata, rx_data;
   wire        scl_oe, sda_oe, start_detect, stop_detect, channel_reinit, ack_event;
   wire        nack_event, scl_low, sda_low, p_busy, ack_bit;
   // Pull-ups: a line is high unless some party pulls it low
   wire        scl = !(scl_oe | scl_low);
   wire        sda = !(sda_oe | sda_low);
   integer     error_cnt = 0, total_checks = 0, seed = 32'hf7776714, i, k, r0, a0;
   integer     n_st = 0, n_sp = 0, n_ri = 0, n_ack = 0, n_nack = 0;
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      n_st <= n_st + start_detect;
      n_sp <= n_sp + stop_detect;
      n_ri <= n_ri + channel_reinit;
      n_ack <= n_ack + ack_event;
      n_nack <= n_nack + nack_event;
   end
   imbc_top i_imbc_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .master_mode(master_mode),
      .bit_rate_div(bit_rate_div), .tx_data_bit(tx_data_bit), .arb_lost(arb_lost),
      .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .start_detect(start_detect), .stop_detect(stop_detect),
      .channel_reinit(channel_reinit), .ninth_fall(), .ack_event(ack_event),
      .nack_event(nack_event), .xfer_event(), .rx_load(), .bus_busy(), .rx_data(rx_data));
   imbc_peer i_imbc_peer (.go(go), .tx_byte(byte_v), .scl(scl), .sda(sda),
      .scl_low(scl_low), .sda_low(sda_low), .busy(p_busy), .ack_bit(ack_bit));
   function logic [7:0] expect_rd(input logic [1:0] a, input logic [7:0] d);
      return (a == 2'h2) ? (d & 8'hF8) : (a == 2'h1) ? d : (d & 8'h7F);
   endfunction
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input logic [1:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
      @(posedge clk);
   endtask
   task final_report;
      if (error_cnt == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #400000;
      error_cnt = error_cnt + 1;
      final_report;
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      bit_rate_div <= 8'h03 + ($random(seed) & 8'h0C);
      @(posedge clk);
      for (i = 0; i < 4; i++) rd(i[1:0], 8'h00);
      for (i = 0; i < 12; i++) begin
         v = $random(seed);
         tx_data_bit <= $random(seed);
         wr(i[1:0], (i % 4 == 2) ? (v & 8'hF8) : v);
         rd(i[1:0], expect_rd(i[1:0], v));
      end
      wr(2'h0, 8'h60);
      chk({7'h00, scl_oe}, 8'h01);
      chk({7'h00, sda_oe}, 8'h00);
      wr(2'h1, 8'h00);
      tx_data_bit <= 1'b1;
      // Slave frames: ack and nack, both event timings, both hold bits
      for (i = 0; i < 4; i++) begin
         v = $random(seed);
         byte_v <= v;
         wr(2'h0, (i == 2) ? 8'h14 : {7'h08, i[1]});
         wr(2'h2, (i == 3) ? 8'hA0 : {3'h1, i[0], 4'h0});
         r0 = n_ri;
         a0 = (i == 1) ? n_nack : n_ack;
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         if (i > 1) begin
            repeat (600) @(posedge clk);
            chk({7'h00, scl_oe}, 8'h01);
            wr((i == 2) ? 2'h0 : 2'h2, (i == 2) ? 8'h10 : 8'h20);
         end
         for (k = 0; k < 20000 && p_busy; k++) @(posedge clk);
         chk({7'h00, p_busy}, 8'h00);
         chk({7'h00, ack_bit}, (i == 1) ? 8'h01 : 8'h00);
         chk({7'h00, ((i == 1) ? n_nack : n_ack) > a0}, 8'h01);
         chk(rx_data, v);
         chk({7'h00, n_ri > r0}, 8'h01);
      end
      master_mode <= 1'b1;
      wr(2'h0, 8'h02);
      wr(2'h2, 8'h01);
      r0 = n_st;
      repeat (300) @(posedge clk);
      chk({7'h00, n_st > r0}, 8'h00);
      // Start, repeated start, then stop
      for (i = 0; i < 3; i++) begin
         r0 = (i == 2) ? n_sp : n_st;
         wr(2'h2, (i == 0) ? 8'h09 : (i == 1) ? 8'h0A : 8'h0C);
         for (k = 0; k < 4000 && ((i == 2) ? n_sp : n_st) == r0; k++) @(posedge clk);
         chk({7'h00, ((i == 2) ? n_sp : n_st) > r0}, 8'h01);
         repeat (200) @(posedge clk);
      end
      wr(2'h2, 8'h00);
      wr(2'h0, 8'h0A);
      tx_data_bit <= 1'b0;
      repeat (4) @(posedge clk);
      chk({7'h00, sda_oe}, 8'h01);
      arb_lost <= 1'b1;
      repeat (4) @(posedge clk);
      chk({7'h00, sda_oe}, 8'h00);
      arb_lost <= 1'b0;
      final_report;
   end
endmodule
`default_nettype wire
